/* rtl/gate_phase_seq.sv */
// Steps the six gate phase clocks on or off in fixed order.
// Assumes start pulses come from the power sequencer.
`timescale 1ns/1ps
`default_nettype none
module gate_phase_seq
   import panel_drive_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic              stepTick,
   input  wire logic              turnOn,
   input  wire logic              turnOff,
   output logic [PHASES-1:0]      phaseEnable,
   output logic                   allOn,
   output logic                   allOff
);
   // Order index k maps to phase (k+3)%6: 4,5,6,1,2,3
   logic [PHASES-1:0] order_reg;
   logic [PHASES-1:0] order_next;
   logic              dirOn_reg;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         order_reg <= 6'h00;
         dirOn_reg <= 1'b0;
      end else begin
         order_reg <= order_next;
         if (turnOn)
            dirOn_reg <= 1'b1;
         else if (turnOff)
            dirOn_reg <= 1'b0;
      end
   end

   // Fill from index 0 upward, drain by clearing the lowest set index
   wire [PHASES-1:0] filled  = {order_reg[PHASES-2:0], 1'b1};
   wire [PHASES-1:0] drained = order_reg & (order_reg - 6'h01);
   assign order_next = !stepTick ? order_reg :
                       dirOn_reg ? filled : drained;

   genvar g;
   generate
      for (g = 0; g < PHASES; g++) begin : g_map
         assign phaseEnable[(g + 3) % PHASES] = order_reg[g];
      end
   endgenerate

   assign allOn  = &order_reg;
   assign allOff = ~|order_reg;

   a_phase_fill: assert property (@(posedge clock)
      disable iff (reset)
      (stepTick && dirOn_reg && !allOn) |=>
      $countones(order_reg) == $countones($past(order_reg)) + 1)
      else $error("phase clocks did not turn on one step");
   a_phase_drain: assert property (@(posedge clock)
      disable iff (reset)
      (stepTick && !dirOn_reg && !allOff) |=>
      $countones(order_reg) + 1 == $countones($past(order_reg)))
      else $error("phase clocks did not turn off one step");
   a_phase_first: assert property (@(posedge clock)
      disable iff (reset)
      $rose(|phaseEnable) |-> phaseEnable == PHASE_ORDER_0)
      else $error("first phase clock on is not phase 4");
endmodule
`default_nettype wire

/* rtl/lane_edge_detect.sv */
// Samples the lane clock and flags its rising edges.
// Assumes laneClock is asynchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module lane_edge_detect
   import panel_drive_pkg::*;
(
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic laneClock,
   output logic      laneRise
);
   logic syncA_reg;
   logic syncB_reg;
   logic prev_reg;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         syncA_reg <= 1'b0;
         syncB_reg <= 1'b0;
         prev_reg  <= 1'b0;
      end else begin
         syncA_reg <= laneClock;
         syncB_reg <= syncA_reg;
         prev_reg  <= syncB_reg;
      end
   end

   assign laneRise = syncB_reg & ~prev_reg;
endmodule
`default_nettype wire

/* rtl/panel_drive_pkg.sv */
// Constants for the panel timing controller.
// Assumes a 10 MHz system clock and a lane clock slower than it.
// Behaviour
// - Pixel data and reset share six lanes
// - Ten lane clocks after data before strobe
// - Reset word high three lane clocks
// - Strobe rises only after reset low
// - 200 ns from strobe to next reset
// - Strobe pulse at least 200 ns wide
// - Start pulse set up 100 ns before strobe
// - Start pulse held 100 ns after strobe
// - Odd-row supply enable high first
// - Odd and even supplies never both high
// - Supply swap only in vertical blanking
// - Phase clocks on/off order 4,5,6,1,2,3
// - Power-down drops supplies after phase clocks, reverse of power-up
package panel_drive_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int LANES = 6;
   localparam int PHASES = 6;
   localparam int RX_OFF_CYCLES = 10;
   localparam int RESET_HIGH_CYCLES = 3;
   localparam int STROBE_TO_RESET_NS = 200;
   localparam int STROBE_WIDTH_NS = 200;
   localparam int START_SETUP_NS = 100;
   localparam int START_HOLD_NS = 100;
   localparam int STROBE_TO_RESET_CYC =
      (STROBE_TO_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_WIDTH_CYC =
      (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int START_SETUP_CYC =
      (START_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int START_HOLD_CYC =
      (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STEP_CYCLES = 4;
   localparam int WORDS_PER_LINE = 8;
   localparam int LINES_PER_FRAME = 6;
   localparam int BLANK_LINES = 2;
   localparam logic [5:0] RESET_WORD = 6'h3F;
   localparam logic [5:0] PHASE_ORDER_0 = 6'h08;
   localparam int CNT_W = 8;
endpackage

/* rtl/panel_timing_ctrl.sv */
// Panel timing controller: lanes, strobe, start pulse, gate drive.
// Assumes a lane clock input, a pixel word source, and a run request.
`timescale 1ns/1ps
`default_nettype none
module panel_timing_ctrl
   import panel_drive_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             laneClock,
   input  wire logic             runRequest,
   input  wire logic [LANES-1:0] pixelWord,
   output logic                  pixelTake,
   output logic [LANES-1:0]      serialDataLanes,
   output logic                  sourceOutputStrobe,
   output logic                  polaritySelect,
   output logic                  gateScanStart,
   output logic [PHASES-1:0]     gatePhaseClock,
   output logic                  oddRowGateSupplyEnable,
   output logic                  evenRowGateSupplyEnable,
   output logic                  powerReady
);
   typedef enum logic [8:0] {
      S_OFF    = 9'h001,
      S_PHON   = 9'h002,
      S_RESET  = 9'h004,
      S_DATA   = 9'h008,
      S_RXOFF  = 9'h010,
      S_SETUP  = 9'h020,
      S_STROBE = 9'h040,
      S_GAP    = 9'h080,
      S_PHOFF  = 9'h100
   } state_e;

   state_e           state_reg;
   state_e           state_next;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] line_reg;
   logic [CNT_W-1:0] stepDiv_reg;
   logic [LANES-1:0] lanes_reg;
   logic             strobe_reg;
   logic             start_reg;
   logic             pol_reg;
   logic             odd_reg;
   logic             even_reg;
   logic             laneRise;
   logic             phaseAllOn;
   logic             phaseAllOff;

   lane_edge_detect u_edge (
      .clock     (clock),
      .reset     (reset),
      .laneClock (laneClock),
      .laneRise  (laneRise)
   );

   wire stepTick = (stepDiv_reg == CNT_W'(STEP_CYCLES - 1));
   wire inOff    = (state_reg == S_OFF);
   wire inPhon   = (state_reg == S_PHON);
   wire inPhoff  = (state_reg == S_PHOFF);

   gate_phase_seq u_phase (
      .clock       (clock),
      .reset       (reset),
      .stepTick    (stepTick),
      .turnOn      (inOff & runRequest),
      .turnOff     (inPhoff),
      .phaseEnable (gatePhaseClock),
      .allOn       (phaseAllOn),
      .allOff      (phaseAllOff)
   );

   // Line and frame position
   wire lastWord   = (count_reg == CNT_W'(WORDS_PER_LINE - 1));
   wire lastLine   = (line_reg ==
                      CNT_W'(LINES_PER_FRAME + BLANK_LINES - 1));
   wire blanking   = (line_reg >= CNT_W'(LINES_PER_FRAME));
   wire frameFirst = (line_reg == CNT_W'(0));
   wire resetDone  = laneRise &&
                     (count_reg == CNT_W'(RESET_HIGH_CYCLES - 1));
   wire rxOffDone  = laneRise &&
                     (count_reg == CNT_W'(RX_OFF_CYCLES - 1));
   wire setupDone  = (count_reg == CNT_W'(START_SETUP_CYC - 1));
   wire widthDone  = (count_reg == CNT_W'(STROBE_WIDTH_CYC - 1));
   wire gapCycles  = (STROBE_TO_RESET_CYC > START_HOLD_CYC) ?
                     1'b1 : 1'b0;
   wire gapDone    = (count_reg == CNT_W'((gapCycles ?
                     STROBE_TO_RESET_CYC : START_HOLD_CYC) - 1));
   wire stopReq    = ~runRequest;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         S_OFF:    if (runRequest) state_next = S_PHON;
         S_PHON:   if (phaseAllOn) state_next = S_RESET;
         S_RESET:  if (resetDone) state_next = S_DATA;
         S_DATA:   if (laneRise && lastWord) state_next = S_RXOFF;
         S_RXOFF:  if (rxOffDone) state_next = S_SETUP;
         S_SETUP:  if (setupDone) state_next = S_STROBE;
         S_STROBE: if (widthDone) state_next = S_GAP;
         S_GAP:    if (gapDone)
                      state_next = stopReq ? S_PHOFF : S_RESET;
         S_PHOFF:  if (phaseAllOff) state_next = S_OFF;
         default:  state_next = S_OFF;
      endcase
   end

   wire stateChange = (state_next != state_reg);
   wire laneStates  = (state_reg == S_RESET) || (state_reg == S_DATA) ||
                      (state_reg == S_RXOFF);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_reg   <= S_OFF;
         count_reg   <= '0;
         stepDiv_reg <= '0;
      end else begin
         state_reg   <= state_next;
         stepDiv_reg <= stepTick ? '0 : stepDiv_reg + CNT_W'(1);
         if (stateChange)
            count_reg <= '0;
         else if (!laneStates || laneRise)
            count_reg <= count_reg + CNT_W'(1);
      end
   end

   // Line counter, one strobe per line
   always_ff @(posedge clock or posedge reset) begin
      if (reset)
         line_reg <= '0;
      else if (inOff)
         line_reg <= '0;
      else if (state_reg == S_GAP && gapDone)
         line_reg <= lastLine ? '0 : line_reg + CNT_W'(1);
   end

   // Lane output: reset word then pixel words on the same lanes
   wire [LANES-1:0] lanesNext =
      (state_reg == S_RESET) ? RESET_WORD :
      (state_reg == S_DATA)  ? pixelWord : '0;
   assign pixelTake = (state_reg == S_DATA) && laneRise;

   always_ff @(posedge clock or posedge reset) begin
      if (reset)
         lanes_reg <= '0;
      else if (laneRise || !laneStates)
         lanes_reg <= lanesNext;
   end

   // Strobe only after reset low and receiver idle
   wire strobeNext = (state_next == S_STROBE);
   // Start pulse spans setup, strobe and hold on the first line
   wire startNext  = frameFirst && ((state_next == S_SETUP) ||
                     (state_next == S_STROBE) ||
                     ((state_next == S_GAP) &&
                      !(state_reg == S_GAP && count_reg >=
                        CNT_W'(START_HOLD_CYC - 1))));

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         strobe_reg <= 1'b0;
         start_reg  <= 1'b0;
         pol_reg    <= 1'b0;
      end else begin
         strobe_reg <= strobeNext;
         start_reg  <= startNext;
         if (state_reg == S_GAP && gapDone)
            pol_reg <= ~pol_reg;
      end
   end

   // Odd supply first, swap only in blanking, never both high
   wire frameEnd = (state_reg == S_GAP) && gapDone && lastLine;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         odd_reg  <= 1'b0;
         even_reg <= 1'b0;
      end else if (inOff) begin
         odd_reg  <= runRequest;
         even_reg <= 1'b0;
      end else if (inPhoff && phaseAllOff) begin
         odd_reg  <= 1'b0;
         even_reg <= 1'b0;
      end else if (frameEnd && blanking) begin
         odd_reg  <= even_reg;
         even_reg <= odd_reg;
      end
   end

   assign serialDataLanes         = lanes_reg;
   assign sourceOutputStrobe      = strobe_reg;
   assign polaritySelect          = pol_reg;
   assign gateScanStart           = start_reg;
   assign oddRowGateSupplyEnable  = odd_reg;
   assign evenRowGateSupplyEnable = even_reg;
   assign powerReady              = ~inOff & ~inPhon & ~inPhoff;

   // Checker counters: idle lane clocks, reset word length, line words
   logic [CNT_W-1:0] idleSeen_reg;
   logic [CNT_W-1:0] resetSeen_reg;
   logic [CNT_W-1:0] wordsSeen_reg;
   wire              resetOnLanes = (lanes_reg == RESET_WORD);

   always_ff @(posedge clock or posedge reset) begin
      if (reset)
         idleSeen_reg <= '0;
      else if (pixelTake)
         idleSeen_reg <= '0;
      else if (laneRise && idleSeen_reg != '1)
         idleSeen_reg <= idleSeen_reg + CNT_W'(1);
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset)
         resetSeen_reg <= '0;
      else if (!resetOnLanes)
         resetSeen_reg <= '0;
      else if (laneRise && resetSeen_reg != '1)
         resetSeen_reg <= resetSeen_reg + CNT_W'(1);
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset)
         wordsSeen_reg <= '0;
      else if (strobe_reg)
         wordsSeen_reg <= '0;
      else if (pixelTake && wordsSeen_reg != '1)
         wordsSeen_reg <= wordsSeen_reg + CNT_W'(1);
   end

   sequence s_strobe_rise;
      $rose(sourceOutputStrobe);
   endsequence

   sequence s_start_rise;
      $rose(gateScanStart);
   endsequence

   a_supply_exclusive: assert property (@(posedge clock)
      disable iff (reset) !(odd_reg && even_reg))
      else $error("odd and even supplies both high");
   a_supply_blank: assert property (@(posedge clock)
      disable iff (reset)
      ($changed(even_reg) && !inOff && !inPhoff) |-> $past(blanking))
      else $error("supply swapped outside blanking");
   a_supply_odd_first: assert property (@(posedge clock)
      disable iff (reset) $rose(even_reg) |-> !$past(inOff))
      else $error("even supply started first");
   a_odd_at_start: assert property (@(posedge clock)
      disable iff (reset)
      $rose(powerReady) |-> (odd_reg && !even_reg))
      else $error("scan started without odd supply alone");
   a_strobe_width: assert property (@(posedge clock)
      disable iff (reset) s_strobe_rise |-> sourceOutputStrobe [*2])
      else $error("strobe pulse too narrow");
   a_strobe_reset_low: assert property (@(posedge clock)
      disable iff (reset)
      s_strobe_rise |-> serialDataLanes != RESET_WORD)
      else $error("strobe rose while reset word on lanes");
   a_rx_idle_first: assert property (@(posedge clock)
      disable iff (reset)
      s_strobe_rise |-> idleSeen_reg >= CNT_W'(RX_OFF_CYCLES))
      else $error("strobe too soon after last data word");
   a_reset_word_long: assert property (@(posedge clock)
      disable iff (reset)
      ($past(resetOnLanes) && !resetOnLanes) |->
      resetSeen_reg >= CNT_W'(RESET_HIGH_CYCLES))
      else $error("reset word held too few lane clocks");
   a_line_words_done: assert property (@(posedge clock)
      disable iff (reset)
      s_strobe_rise |-> wordsSeen_reg == CNT_W'(WORDS_PER_LINE))
      else $error("strobe before the whole line was sent");
   a_start_setup: assert property (@(posedge clock)
      disable iff (reset)
      (s_strobe_rise and gateScanStart) |-> $past(gateScanStart))
      else $error("start pulse setup too short");
   a_start_leads: assert property (@(posedge clock)
      disable iff (reset) s_start_rise |=> s_strobe_rise)
      else $error("strobe did not follow start pulse");
   a_start_hold: assert property (@(posedge clock)
      disable iff (reset)
      ($fell(sourceOutputStrobe) && $past(gateScanStart)) |->
      gateScanStart)
      else $error("start pulse hold too short");
   a_start_first_line: assert property (@(posedge clock)
      disable iff (reset)
      s_start_rise |-> (line_reg == '0) && phaseAllOn)
      else $error("start pulse not on first line");
   a_strobe_gap: assert property (@(posedge clock)
      disable iff (reset)
      $fell(sourceOutputStrobe) |-> (serialDataLanes != RESET_WORD) [*2])
      else $error("reset word too soon after strobe");
   a_idle_unpowered: assert property (@(posedge clock)
      disable iff (reset) !powerReady |-> !sourceOutputStrobe)
      else $error("strobe active before power-up");
   a_phases_ready: assert property (@(posedge clock)
      disable iff (reset)
      powerReady |-> gatePhaseClock == {PHASES{1'b1}})
      else $error("phase clock off while scanning");
   a_phases_before_off: assert property (@(posedge clock)
      disable iff (reset)
      $fell(odd_reg || even_reg) |-> gatePhaseClock == '0)
      else $error("supply dropped before phase clocks off");
   a_supply_before_on: assert property (@(posedge clock)
      disable iff (reset)
      $rose(|gatePhaseClock) |-> (odd_reg || even_reg))
      else $error("phase clock on before supply");
endmodule
`default_nettype wire

/* tb/panel_model.sv */
// Panel model: latches the lanes and checks the control timing.
// Assumes it watches panel_timing_ctrl; faults is a sticky mask.
`timescale 1ns/1ps
`default_nettype none
module panel_model
   import panel_drive_pkg::*;
(
   input  wire logic              reset,
   input  wire logic              laneClock,
   input  wire logic [LANES-1:0]  lanes,
   input  wire logic              strobe,
   input  wire logic              start,
   input  wire logic [PHASES-1:0] phase,
   input  wire logic              odd,
   input  wire logic              even,
   input  wire logic              ready,
   output logic      [16:0]       faults
);
   int                rstRises = 0, idleRises = 0, words = 0;
   int                lines = 0, step = 0;
   bit                frame, oddSeen, supFirst, prevSup;
   realtime           tRise, tStart, tFall = -1.0e6;
   logic [LANES-1:0]  prevLane;
   logic [PHASES-1:0] prevPh = '0;
   int                order [6] = '{3, 4, 5, 0, 1, 2};
   initial faults = '0;
   always @(posedge reset) begin
      step = 0;
      words = 0;
      lines = 0;
      frame = 0;
   end
   always @(posedge laneClock) begin
      idleRises++;
      if (lanes == RESET_WORD) rstRises++;
   end
   always @(lanes) begin
      if (!reset && prevLane == RESET_WORD && lanes != RESET_WORD &&
          rstRises < RESET_HIGH_CYCLES) faults[3] = 1'h1;
      if (lanes == RESET_WORD) begin
         if ($realtime - tFall < STROBE_TO_RESET_NS) faults[5] = 1'h1;
         rstRises = 0;
      end else if (lanes != '0) begin
         words++;
         idleRises = 0;
      end
      prevLane = lanes;
   end
   always @(posedge strobe) begin
      tRise = $realtime;
      if (idleRises < RX_OFF_CYCLES) faults[2] = 1'h1;
      if (lanes == RESET_WORD) faults[4] = 1'h1;
      if (start && tRise - tStart < START_SETUP_NS) faults[7] = 1'h1;
      if (words != WORDS_PER_LINE) faults[14] = 1'h1;
      if (phase != '1) faults[16] = 1'h1;
      words = 0;
      lines++;
   end
   always @(negedge strobe) begin
      if (!reset && $realtime - tRise < STROBE_WIDTH_NS)
         faults[6] = 1'h1;
      tFall = $realtime;
   end
   always @(posedge start) begin
      tStart = $realtime;
      if (phase != '1) faults[16] = 1'h1;
      if (frame && lines != LINES_PER_FRAME + BLANK_LINES)
         faults[15] = 1'h1;
      frame = 1;
      lines = 0;
   end
   always @(negedge start)
      if (!reset && (strobe || $realtime - tFall < START_HOLD_NS))
         faults[8] = 1'h1;
   always @(phase) begin
      if (!reset && (phase ^ prevPh) != (6'h01 << order[step % 6]))
         faults[12] = 1'h1;
      if (!reset) step++;
      if (prevPh == '0 && phase != '0) supFirst = odd | even;
      if (phase == '0) frame = 0;
      prevPh = phase;
   end
   always @(odd or even) begin
      #1;
      if (odd && even) faults[10] = 1'h1;
      if (!reset && !ready && prevSup && !odd && !even &&
          (phase == '0) != supFirst) faults[13] = 1'h1;
      prevSup = odd | even;
   end
   always @(posedge odd or posedge even) begin
      oddSeen = oddSeen | odd;
      if (!oddSeen) faults[9] = 1'h1;
      if (frame && lines < LINES_PER_FRAME) faults[11] = 1'h1;
   end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Testbench: runs the panel timing controller against the panel model.
// Assumes the package, the controller and panel_model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import panel_drive_pkg::*;
;
   logic              clock = 0, reset = 1, laneClock = 0, runRequest = 0;
   logic [LANES-1:0]  pixelWord = 6'h01, lanes;
   logic              pixelTake, strobe, polarity_select, start, odd, even, ready;
   logic [PHASES-1:0] phase;
   logic [16:0]       faults;
   logic [LANES-1:0]  expQ [$];
   int                numErrors = 0, numChecks = 0, cycles = 0;
   panel_timing_ctrl i_panel_timing_ctrl (
      .clock(clock), .reset(reset), .laneClock(laneClock),
      .runRequest(runRequest), .pixelWord(pixelWord), .pixelTake(pixelTake),
      .serialDataLanes(lanes), .sourceOutputStrobe(strobe),
      .polaritySelect(polarity_select), .gateScanStart(start), .gatePhaseClock(phase),
      .oddRowGateSupplyEnable(odd), .evenRowGateSupplyEnable(even),
      .powerReady(ready));
   panel_model i_panel_model (
      .reset(reset), .laneClock(laneClock), .lanes(lanes), .strobe(strobe),
      .start(start), .phase(phase), .odd(odd), .even(even), .ready(ready),
      .faults(faults));
   initial forever #50 clock = ~clock;
   initial #37 forever #400 laneClock = ~laneClock;
   task automatic check(input logic [31:0] got, exp);
      numChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic printVerdict();
      $display("Checks %0d errors %0d", numChecks, numErrors);
      if (numErrors == 0 && numChecks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 12000) begin
         numErrors++;
         printVerdict();
      end
      if (pixelTake === 1'h1 && !reset) begin
         expQ.push_back(pixelWord);
         pixelWord <= #1 pixelWord % 6'h3E + 6'h01;
      end
   end
   always @(posedge reset) expQ.delete();
   always @(lanes)
      if (!reset && lanes != RESET_WORD && lanes != '0)
         check(lanes, expQ.pop_front());
   task automatic pulseReset();
      #1 reset = 1'h1;
      runRequest = 1'h0;
      repeat (3) @(posedge clock);
      #1 reset = 1'h0;
      @(posedge clock);
      #1 check({lanes, strobe, polarity_select, start, phase, odd, even, ready}, 0);
   endtask
   task automatic powerUp();
      @(posedge clock) #1 runRequest = 1'h1;
      for (int i = 0; i < 300 && ready !== 1'h1; i++) @(posedge clock);
      check({ready, phase}, {1'h1, 6'h3F});
      check({odd, even}, 2'h2);
   endtask
   task automatic twoFrames();
      int         starts = 0, lines = 0;
      bit         pS = 0, pT = 0;
      logic [1:0] sup [3];
      for (int i = 0; i < 6000 && starts < 3; i++) begin
         @(posedge clock);
         if (strobe && !pS) lines++;
         if (start && !pT) begin
            sup[starts] = {odd, even};
            starts++;
            if (starts == 1) lines = 0;
         end
         pS = strobe;
         pT = start;
      end
      check(lines, 2 * (LINES_PER_FRAME + BLANK_LINES));
      check(sup[1] ^ sup[2], 2'h3);
   endtask
   task automatic powerDown();
      @(posedge clock) #1 runRequest = 1'h0;
      for (int i = 0; i < 800 && {phase, odd, even} !== 0; i++)
         @(posedge clock);
      check({phase, odd, even, ready, strobe}, 0);
   endtask
   initial begin
      pulseReset();
      powerUp();
      twoFrames();
      powerDown();
      powerUp();
      repeat (300) @(posedge clock);
      pulseReset();
      powerUp();
      powerDown();
      check(faults, 0);
      printVerdict();
   end
endmodule
`default_nettype wire
